//--- design/ssu_sink.sv
// receive-side user interface of a multi-lane streaming link
module ssu_sink (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic core_reset_in,
    input wire logic adv_clk_mode_in,
    input wire logic burst_mode_in,
    input wire logic ecc_en_in,
    input wire logic init_done_in,
    input wire logic [ssu_pkg::DATA_W-1:0] lane_data_in,
    input wire logic lane_valid_in,
    input wire logic lane_first_in,
    input wire logic lane_last_in,
    input wire logic [ssu_pkg::SYNC_W-1:0] lane_sync_in,
    input wire logic [ssu_pkg::LANES-1:0] lane_crc_err_in,
    input wire logic align_lost_in,
    input wire logic seu_corr_in,
    input wire logic seu_uncorr_in,
    output logic lane_ready_out,
    output logic user_clk_out,
    output logic user_reset_out,
    output logic iface_clk_out,
    output logic iface_reset_out,
    output logic link_up_out,
    output logic [ssu_pkg::DATA_W-1:0] sink_data_out,
    output logic [ssu_pkg::SYNC_W-1:0] sink_sync_out,
    output logic sink_valid_out,
    output logic sink_burst_first_out,
    output logic sink_burst_last_out,
    output logic [ssu_pkg::ERR_W-1:0] sink_error_out,
    input wire logic sink_ready_in,
    input wire logic [ssu_pkg::ST_W-1:0] err_enable_in,
    input wire logic [ssu_pkg::ST_W-1:0] err_clear_in,
    output logic [ssu_pkg::ST_W-1:0] err_status_out,
    output logic err_irq_out,
    input wire logic crc_inject_in,
    input wire logic [ssu_pkg::CRC_W-1:0] tx_crc_in,
    output logic [ssu_pkg::CRC_W-1:0] tx_crc_out
);
    // master reset joins the board reset asynchronously, release is synchronised
    logic arst_n;
    logic rst_meta;
    logic rst_n;
    assign arst_n = rstn_in & ~core_reset_in;

    always_ff @(posedge mclk_in or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // reset sequence timer
    logic [ssu_pkg::RST_CNT_W-1:0] rst_cnt;
    logic [ssu_pkg::RST_CNT_W-1:0] next_rst_cnt;
    logic seq_busy;
    logic next_seq_busy;

    always_comb begin
        next_rst_cnt = rst_cnt;
        next_seq_busy = seq_busy;
        if (seq_busy) begin
            if (rst_cnt == ssu_pkg::RST_CNT_LAST) begin
                next_seq_busy = 1'b0;
            end else begin
                next_rst_cnt = rst_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= '0;
            seq_busy <= 1'b1;
        end else begin
            rst_cnt <= next_rst_cnt;
            seq_busy <= next_seq_busy;
        end
    end

    // each mode's reset stays asserted in the other mode
    assign user_reset_out = seq_busy | adv_clk_mode_in;
    assign iface_reset_out = seq_busy | ~adv_clk_mode_in;

    // interface clock and transfer enable
    logic xfer_en;
    logic clk_lvl;

    ssu_clkdiv u_div (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .xfer_en_out(xfer_en),
        .clk_lvl_out(clk_lvl)
    );

    assign iface_clk_out = clk_lvl & adv_clk_mode_in;
    assign user_clk_out = clk_lvl & ~adv_clk_mode_in;

    // crc injection pin, synchronised before use
    logic inj_meta;
    logic inj_sync;
    logic [ssu_pkg::CRC_W-1:0] crc_q;
    logic [ssu_pkg::CRC_W-1:0] next_crc;

    always_comb begin
        next_crc = tx_crc_in ^ {ssu_pkg::CRC_W{inj_sync}};
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            inj_meta <= 1'b0;
            inj_sync <= 1'b0;
            crc_q <= '0;
        end else begin
            inj_meta <= crc_inject_in;
            inj_sync <= inj_meta;
            crc_q <= next_crc;
        end
    end

    assign tx_crc_out = crc_q;

    // link status
    logic link_up;
    logic next_link_up;

    always_comb begin
        next_link_up = ~seq_busy & init_done_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            link_up <= 1'b0;
        end else begin
            link_up <= next_link_up;
        end
    end

    assign link_up_out = link_up;

    // output stage holding one word
    logic out_vld;
    logic out_first;
    logic out_last;
    logic [ssu_pkg::DATA_W-1:0] out_data;
    logic [ssu_pkg::SYNC_W-1:0] out_sync;
    logic seen_first;
    logic in_burst;
    logic next_out_vld;
    logic next_out_first;
    logic next_out_last;
    logic [ssu_pkg::DATA_W-1:0] next_out_data;
    logic [ssu_pkg::SYNC_W-1:0] next_out_sync;
    logic next_seen_first;
    logic next_in_burst;
    logic take;
    logic drain;
    logic overflow_ev;
    logic ready_drop_ev;

    assign drain = xfer_en & out_vld & sink_ready_in;
    assign lane_ready_out = link_up & xfer_en & (~out_vld | sink_ready_in);
    assign take = lane_valid_in & lane_ready_out;
    // words arrive only in transfer cycles, so only a refusal there loses one
    assign overflow_ev = link_up & xfer_en & lane_valid_in & ~lane_ready_out;
    assign ready_drop_ev = xfer_en & in_burst & ~sink_ready_in;

    always_comb begin
        next_out_vld = out_vld;
        next_out_first = out_first;
        next_out_last = out_last;
        next_out_data = out_data;
        next_out_sync = out_sync;
        next_seen_first = seen_first;
        next_in_burst = in_burst;
        if (drain) begin
            next_out_vld = 1'b0;
            if (out_first) begin
                next_in_burst = burst_mode_in;
            end
            if (out_last) begin
                next_in_burst = 1'b0;
            end
        end
        if (take) begin
            next_out_vld = 1'b1;
            next_out_data = lane_data_in;
            next_out_sync = lane_sync_in;
            next_out_first = lane_first_in & (burst_mode_in | ~seen_first);
            next_out_last = lane_last_in;
            if (lane_first_in) begin
                next_seen_first = 1'b1;
            end
        end
        if (!link_up) begin
            next_out_vld = 1'b0;
            next_seen_first = 1'b0;
            next_in_burst = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            out_vld <= 1'b0;
            out_first <= 1'b0;
            out_last <= 1'b0;
            out_data <= '0;
            out_sync <= '0;
            seen_first <= 1'b0;
            in_burst <= 1'b0;
        end else begin
            out_vld <= next_out_vld;
            out_first <= next_out_first;
            out_last <= next_out_last;
            out_data <= next_out_data;
            out_sync <= next_out_sync;
            seen_first <= next_seen_first;
            in_burst <= next_in_burst;
        end
    end

    assign sink_valid_out = out_vld;
    assign sink_data_out = out_data;
    assign sink_sync_out = out_sync;
    assign sink_burst_first_out = out_vld & out_first;
    assign sink_burst_last_out = out_vld & out_last;

    // error vector
    logic [ssu_pkg::ERR_W-1:0] err_vec;
    logic [ssu_pkg::ERR_W-1:0] next_err_vec;

    always_comb begin
        next_err_vec = '0;
        next_err_vec[ssu_pkg::ERR_SEU_UNCORR] = seu_uncorr_in & ecc_en_in & ~adv_clk_mode_in;
        next_err_vec[ssu_pkg::ERR_SEU_CORR] = seu_corr_in & ecc_en_in & ~adv_clk_mode_in;
        next_err_vec[ssu_pkg::ERR_OVERFLOW] = overflow_ev;
        next_err_vec[ssu_pkg::ERR_ZERO] = 1'b0;
        next_err_vec[ssu_pkg::ERR_ALIGN] = align_lost_in;
        next_err_vec[ssu_pkg::LANES-1:0] = lane_crc_err_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            err_vec <= '0;
        end else begin
            err_vec <= next_err_vec;
        end
    end

    assign sink_error_out = err_vec;

    // sticky status and interrupt
    ssu_err_if u_err_if ();

    assign u_err_if.event_bits = {ready_drop_ev, overflow_ev, align_lost_in, lane_crc_err_in};
    assign u_err_if.enable = err_enable_in;
    assign u_err_if.clear = err_clear_in;
    assign err_status_out = u_err_if.status;
    assign err_irq_out = u_err_if.irq;

    ssu_errstat u_stat (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .err(u_err_if.keep)
    );

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence s_seq_end;
        seq_busy ##1 !seq_busy;
    endsequence

    a_reset_release: assert property ($rose(rst_n) |-> seq_busy [*8] ##1 seq_busy ##1 s_seq_end)
        else $error("reset sequence length wrong");
    a_user_reset: assert property (!adv_clk_mode_in |-> (user_reset_out == seq_busy))
        else $error("user reset mismatch");
    a_iface_reset: assert property (adv_clk_mode_in && seq_busy |-> iface_reset_out)
        else $error("interface reset released early");
    a_link_gate: assert property (link_up_out |-> $past(init_done_in) && !$past(seq_busy))
        else $error("link up without init");
    a_stall_hold: assert property (out_vld && !sink_ready_in && link_up |=> out_vld && $stable(out_data))
        else $error("data lost under stall");
    a_first_once: assert property (!burst_mode_in && seen_first && link_up && take |=> !out_first)
        else $error("second first marker in continuous mode");
    a_seu_adv: assert property ($past(adv_clk_mode_in) |-> sink_error_out[ssu_pkg::ERR_SEU_CORR +: 2] == 2'h0)
        else $error("upset bits set in advanced mode");
    a_zero_bit: assert property (sink_error_out[ssu_pkg::ERR_ZERO] == 1'b0)
        else $error("tied bit not zero");
    a_crc_inject: assert property (inj_sync |=> tx_crc_out == ~$past(tx_crc_in))
        else $error("crc not corrupted");
    a_take_valid: assert property (take |=> sink_valid_out && sink_data_out == $past(lane_data_in))
        else $error("taken word not presented");
endmodule

//--- design/ssu_pkg.sv
// constants shared by the receive-side user interface
package ssu_pkg;
    localparam int LANES = 4;
    localparam int WORD_W = 64;
    localparam int DATA_W = WORD_W * LANES;
    localparam int SYNC_W = 8;
    localparam int ERR_W = LANES + 5;
    localparam int ERR_SEU_UNCORR = LANES + 4;
    localparam int ERR_SEU_CORR = LANES + 3;
    localparam int ERR_OVERFLOW = LANES + 2;
    localparam int ERR_ZERO = LANES + 1;
    localparam int ERR_ALIGN = LANES;
    localparam int ST_W = LANES + 3;
    localparam int ST_READY_DROP = LANES + 2;
    localparam int ST_OVERFLOW = LANES + 1;
    localparam int ST_ALIGN = LANES;
    localparam int CRC_W = 32;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_SEQ_NS = 1000;
    localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 4;
    localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(RST_SEQ_CYC - 1);
    localparam int IFCLK_DIV = 2;
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(IFCLK_DIV - 1);
    localparam logic [ST_W-1:0] ST_RESET = '0;
endpackage

//--- design/ssu_err_if.sv
// error status signals between the sink datapath and the status keeper
interface ssu_err_if;
    logic [ssu_pkg::ST_W-1:0] event_bits;
    logic [ssu_pkg::ST_W-1:0] enable;
    logic [ssu_pkg::ST_W-1:0] clear;
    logic [ssu_pkg::ST_W-1:0] status;
    logic irq;
    modport src (output event_bits, output enable, output clear, input status, input irq);
    modport keep (input event_bits, input enable, input clear, output status, output irq);
endinterface

//--- design/ssu_clkdiv.sv
// transfer enable and interface clock divider
module ssu_clkdiv (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    output logic xfer_en_out,
    output logic clk_lvl_out
);
    logic [ssu_pkg::DIV_W-1:0] cnt;
    logic [ssu_pkg::DIV_W-1:0] next_cnt;
    logic lvl;
    logic next_lvl;

    always_comb begin
        next_cnt = (cnt == ssu_pkg::DIV_LAST) ? '0 : cnt + 2'h1;
        next_lvl = (next_cnt == '0);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= '0;
            lvl <= 1'b0;
        end else begin
            cnt <= next_cnt;
            lvl <= next_lvl;
        end
    end

    // rising edge of the interface clock marks each transfer cycle
    assign xfer_en_out = (cnt == ssu_pkg::DIV_LAST);
    assign clk_lvl_out = lvl;
endmodule

//--- design/ssu_errstat.sv
// sticky error status with enable gating onto the error interrupt
module ssu_errstat (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    ssu_err_if.keep err
);
    logic [ssu_pkg::ST_W-1:0] status;
    logic [ssu_pkg::ST_W-1:0] next_status;
    logic irq;
    logic next_irq;

    always_comb begin
        next_status = (status & ~err.clear) | err.event_bits;
        next_irq = |(next_status & err.enable);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status <= ssu_pkg::ST_RESET;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
        end
    end

    assign err.status = status;
    assign err.irq = irq;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_status_sticky: assert property ((|(status & ~err.clear)) |=> (|status))
        else $error("status bit lost without clear");
    a_irq_follows: assert property (##1 (irq == |($past(next_status) & $past(err.enable))))
        else $error("interrupt does not follow enabled status");
    a_event_sets: assert property ((|err.event_bits) |=>
        ((status & $past(err.event_bits)) == $past(err.event_bits)))
        else $error("event did not set its status bit");
endmodule

//--- sim/ssu_user_model.sv
// downstream consumer model for received words
module ssu_user_model #(
    parameter int W = 266
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic xclk_in,
    input wire logic up_in,
    input wire logic valid_in,
    input wire logic [W-1:0] word_in,
    input wire logic stall_in,
    input wire logic drop_in,
    output logic ready_out,
    output logic [W-1:0] log_out [16],
    output int count_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic in_burst;
    logic take;
    // stall only between bursts; drop is the commanded fault
    assign ready_out = ~drop_in & (~stall_in | in_burst);
    // words count only in transfer cycles while the link is up
    assign take = valid_in & ready_out & ~xclk_in & up_in;
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_burst <= 1'b0;
            count_out <= 0;
        end else if (take) begin
            log_out[count_out[3:0]] <= word_in;
            count_out <= count_out + 1;
            in_burst <= (in_burst | word_in[1]) & ~word_in[0];
        end
    end
endmodule

//--- sim/ssu_sink_tb_top.sv
// self-checking bench for the receive-side user interface
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ssu_sink_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [ssu_pkg::DATA_W-1:0] d;
        logic [7:0] s;
        logic f;
        logic l;
    } ssu_row_t;
    ssu_row_t rows [4] = '{
        '{{ssu_pkg::LANES{64'h0123456789ABCDEF}}, 8'h00, 1'b1, 1'b0},
        '{{ssu_pkg::LANES{64'hFEDCBA9876543210}}, 8'h5A, 1'b0, 1'b0},
        '{{ssu_pkg::LANES{64'hA5A5A5A55A5A5A5A}}, 8'h03, 1'b0, 1'b1},
        '{{ssu_pkg::LANES{64'h00000000FFFFFFFF}}, 8'h00, 1'b1, 1'b1}};
    int mismatches = 0, n_checks = 0, cnt;
    logic mclk_in = 1'b0, rstn_in = 1'b0, core_reset_in = 1'b0, adv_clk_mode_in = 1'b0;
    logic burst_mode_in = 1'b1, ecc_en_in = 1'b0, init_done_in = 1'b0, lane_valid_in = 1'b0;
    logic lane_first_in = 1'b0, lane_last_in = 1'b0, align_lost_in = 1'b0, seu_corr_in = 1'b0;
    logic seu_uncorr_in = 1'b0, crc_inject_in = 1'b0, stall = 1'b0, drop = 1'b0;
    logic [ssu_pkg::DATA_W-1:0] lane_data_in = '0, sink_data_out;
    logic [7:0] lane_sync_in = '0, sink_sync_out;
    logic [ssu_pkg::LANES-1:0] lane_crc_err_in = '0;
    logic [ssu_pkg::ST_W-1:0] err_enable_in = '0, err_clear_in = '0, err_status_out;
    logic [31:0] tx_crc_in = '0, tx_crc_out;
    logic [ssu_pkg::ERR_W-1:0] sink_error_out;
    logic lane_ready_out, user_clk_out, user_reset_out, iface_clk_out, iface_reset_out, link_up_out;
    logic sink_valid_out, sink_burst_first_out, sink_burst_last_out, err_irq_out, sink_ready_in;
    logic [265:0] log [16];
    ssu_sink u_ssu_sink (.mclk_in, .rstn_in, .core_reset_in, .adv_clk_mode_in, .burst_mode_in, .ecc_en_in,
        .init_done_in, .lane_data_in, .lane_valid_in, .lane_first_in, .lane_last_in, .lane_sync_in,
        .lane_crc_err_in, .align_lost_in, .seu_corr_in, .seu_uncorr_in, .lane_ready_out, .user_clk_out,
        .user_reset_out, .iface_clk_out, .iface_reset_out, .link_up_out, .sink_data_out, .sink_sync_out,
        .sink_valid_out, .sink_burst_first_out, .sink_burst_last_out, .sink_error_out, .sink_ready_in,
        .err_enable_in, .err_clear_in, .err_status_out, .err_irq_out, .crc_inject_in, .tx_crc_in, .tx_crc_out);
    ssu_user_model u_ssu_user_model (.mclk_in, .rstn_in, .xclk_in(user_clk_out | iface_clk_out),
        .up_in(link_up_out), .valid_in(sink_valid_out),
        .word_in({sink_data_out, sink_sync_out, sink_burst_first_out, sink_burst_last_out}),
        .stall_in(stall), .drop_in(drop), .ready_out(sink_ready_in), .log_out(log), .count_out(cnt));
    initial forever #50 mclk_in = ~mclk_in;
    task automatic final_report;
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic send(input ssu_row_t r);
        int i;
        {lane_data_in, lane_sync_in, lane_first_in, lane_last_in} <= r;
        lane_valid_in <= 1'b1;
        i = 0;
        do begin @(posedge mclk_in); i++; end while (lane_ready_out !== 1'b1 && i < 40);
        `CHK("ready", 1'b1, lane_ready_out)
    endtask
    task automatic wait_cnt(input int n);
        lane_valid_in <= 1'b0;
        for (int i = 0; i < 40 && cnt < n; i++) @(posedge mclk_in);
        `CHK("count", n, cnt)
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    initial begin
        edges(5000);
        mismatches++;
        final_report();
    end
    initial begin
        int i;
        @(negedge mclk_in);
        `CHK("ureset", 1'b1, user_reset_out)
        `CHK("valid", 1'b0, sink_valid_out)
        edges(2);
        rstn_in <= 1'b1;
        edges(8);
        `CHK("ureset", 1'b1, user_reset_out)
        for (i = 0; i < 10 && user_reset_out !== 1'b0; i++) @(posedge mclk_in);
        `CHK("ureset", 1'b0, user_reset_out)
        `CHK("iface_rst", 1'b1, iface_reset_out)
        `CHK("link", 1'b0, link_up_out)
        init_done_in <= 1'b1;
        edges(3);
        `CHK("link", 1'b1, link_up_out)
        foreach (rows[k]) send(rows[k]);
        wait_cnt(4);
        foreach (rows[k]) `CHK("word", rows[k], log[k])
        stall <= 1'b1;
        send(rows[3]);
        edges(2);
        `CHK("lready", 1'b0, lane_ready_out)
        lane_valid_in <= 1'b0;
        for (i = 0; i < 3 && sink_error_out[ssu_pkg::ERR_OVERFLOW] !== 1'b1; i++) @(negedge mclk_in);
        `CHK("ovf", 1'b1, sink_error_out[ssu_pkg::ERR_OVERFLOW])
        @(posedge mclk_in);
        stall <= 1'b0;
        edges(8);
        `CHK("ovf_st", 1'b1, err_status_out[ssu_pkg::ST_OVERFLOW])
        `CHK("count", 5, cnt)
        `CHK("word", rows[3], log[4])
        err_clear_in <= '1;
        @(posedge mclk_in);
        err_clear_in <= '0;
        {ecc_en_in, seu_uncorr_in, align_lost_in, lane_crc_err_in} <= 7'h75;
        @(posedge mclk_in);
        {seu_uncorr_in, align_lost_in, lane_crc_err_in} <= '0;
        @(negedge mclk_in);
        `CHK("errvec", 9'h115, sink_error_out)
        edges(3);
        `CHK("status", 7'h15, err_status_out)
        `CHK("irq", 1'b0, err_irq_out)
        err_enable_in <= 7'h01;
        edges(3);
        `CHK("irq", 1'b1, err_irq_out)
        err_clear_in <= 7'h01;
        @(posedge mclk_in);
        err_clear_in <= '0;
        edges(3);
        `CHK("status", 7'h14, err_status_out)
        `CHK("irq", 1'b0, err_irq_out)
        err_enable_in <= 7'h10;
        edges(3);
        `CHK("irq", 1'b1, err_irq_out)
        err_clear_in <= '1;
        err_enable_in <= '0;
        @(posedge mclk_in);
        err_clear_in <= '0;
        send(rows[0]);
        wait_cnt(6);
        drop <= 1'b1;
        edges(6);
        drop <= 1'b0;
        send(rows[2]);
        wait_cnt(7);
        `CHK("rdrop", 1'b1, err_status_out[ssu_pkg::ST_READY_DROP])
        `CHK("word", rows[2], log[6])
        tx_crc_in <= 32'h1234ABCD;
        edges(4);
        `CHK("crc", 32'h1234ABCD, tx_crc_out)
        crc_inject_in <= 1'b1;
        edges(5);
        `CHK("crc", 32'hEDCB5432, tx_crc_out)
        adv_clk_mode_in <= 1'b1;
        burst_mode_in <= 1'b0;
        core_reset_in <= 1'b1;
        edges(3);
        `CHK("iface_rst", 1'b1, iface_reset_out)
        `CHK("link", 1'b0, link_up_out)
        core_reset_in <= 1'b0;
        for (i = 0; i < 30 && iface_reset_out !== 1'b0; i++) @(posedge mclk_in);
        `CHK("iface_rst", 1'b0, iface_reset_out)
        `CHK("ureset", 1'b1, user_reset_out)
        `CHK("uclk", 1'b0, user_clk_out)
        edges(4);
        send(rows[3]);
        wait_cnt(8);
        `CHK("word", rows[3], log[7])
        send(rows[0]);
        wait_cnt(9);
        `CHK("word", {rows[0].d, rows[0].s, 2'b00}, log[8])
        final_report();
    end
endmodule
